// ===== design/pme_wake_pkg.sv
package pme_wake_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_STATUS_LOW  = 8'hf3;
  localparam logic [7:0] ADDR_STATUS_HIGH = 8'hf4;
  localparam logic [7:0] ADDR_ENABLE_LOW  = 8'hf6;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'hf7;
  localparam logic [7:0] ADDR_ROUTE_SEL   = 8'hfe;
  localparam logic [7:0] ADDR_GPIN_STATUS = 8'hf8;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'hf9;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hfa;

  // ==========================================================
  // Reset values and writable bits
  localparam logic [7:0] RESET_ZERO       = 8'h00;
  localparam logic [7:0] MASK_LOW_GROUP   = 8'h7f;
  localparam logic [7:0] MASK_HIGH_GROUP  = 8'h3f;
  localparam logic [7:0] MASK_ROUTE       = 8'h77;
  localparam logic [7:0] MASK_GPIN        = 8'h07;
  localparam logic [7:0] MASK_IRQ         = 8'h03;

  // ==========================================================
  // Field positions
  localparam int ROUTE_PSW_LSB = 4;
  localparam int ROUTE_PME_LSB = 0;
  localparam int IRQ_BIT_PME   = 0;
  localparam int IRQ_BIT_PSW   = 1;
  localparam int LOW_GROUP_W   = 7;
  localparam int HIGH_GROUP_W  = 6;
  localparam int GPIN_W        = 3;
  localparam int IRQ_W         = 2;
  localparam int REG_W         = 8;
  localparam int HIGH_WDOG_BIT = 2;
endpackage

// ===== design/sync_edge.sv
`timescale 1ns/10ps
// ==========================================================
// Two-flop synchroniser, pulse when pin leaves its idle level
module sync_edge
  import pme_wake_pkg::*;
#(
  parameter bit IDLE_HIGH = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Data
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;
  logic rise_reg, rise_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    last_next = sync_reg;
    rise_next = (sync_reg ^ IDLE_HIGH) & ~(last_reg ^ IDLE_HIGH);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= IDLE_HIGH;
      sync_reg <= IDLE_HIGH;
      last_reg <= IDLE_HIGH;
      rise_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      rise_reg <= rise_next;
    end
  end

  assign rise_pulse = rise_reg;
endmodule // sync_edge

// ===== design/sticky_group.sv
`timescale 1ns/10ps
// ==========================================================
// Sticky write-one-to-clear flags, set wins over clear
module sticky_group
  import pme_wake_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // Events and clear
  input  wire logic [WIDTH-1:0] set_pulse,
  input  wire logic             clear_wr,
  input  wire logic [WIDTH-1:0] clear_bits,
  // Flags
  output logic      [WIDTH-1:0] flags
);
  if (WIDTH < 1 || WIDTH > REG_W) begin : g_bad_width
    $error("sticky_group WIDTH out of range");
  end

  logic [WIDTH-1:0] flag_reg, flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (clear_wr) begin
      flag_next = flag_next & ~clear_bits;
    end
    flag_next = flag_next | set_pulse;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags = flag_reg;
endmodule // sticky_group

// ===== design/pme_wake_event_router.sv
`timescale 1ns/10ps
// What this block does
// - Enable-low bits 6..4 gate port C, mouse, keyboard
// - Enable-low bits 3..0 gate printer, floppy, A, B
// - Enable-high bits 5..3 gate F, E, monitor
// - Enable-high bits 2..0 gate watchdog, D, ring
// - Route bits 6..4 send inputs 27..25 to switch
// - Route bits 2..0 send inputs 27..25 to wake
// - Route register resets to zero
// - Enable-low register resets to zero
// - Enable-high resets zero, bits 7..6 reserved
// - Status bits record events, write one clears
module pme_wake_event_router
  import pme_wake_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Peripheral events, level high = request, except watchdog_timeout_n where low = request
  input  wire logic       serial_port_a_irq,
  input  wire logic       serial_port_b_irq,
  input  wire logic       serial_port_c_irq,
  input  wire logic       serial_port_d_irq,
  input  wire logic       serial_port_e_irq,
  input  wire logic       serial_port_f_irq,
  input  wire logic       keyboard_controller_irq,
  input  wire logic       mouse_irq,
  input  wire logic       printer_port_irq,
  input  wire logic       floppy_controller_irq,
  input  wire logic       hardware_monitor_irq,
  input  wire logic       watchdog_timeout_n,
  input  wire logic       ring_indicate_b,
  // General-purpose input pins
  input  wire logic       gen_input_25,
  input  wire logic       gen_input_26,
  input  wire logic       gen_input_27,
  // Outputs to chipset
  output logic            pme_n,
  output logic            power_switch_output_n,
  output logic            irq
);
  // ==========================================================
  // Elaboration checks on field layout
  if (LOW_GROUP_W < 1 || LOW_GROUP_W >= REG_W) begin : g_bad_low
    $error("low group does not fit below its reserved bit");
  end
  if (HIGH_GROUP_W < 1 || HIGH_GROUP_W > REG_W - 2) begin : g_bad_high
    $error("high group does not fit below its reserved bits");
  end
  if (ROUTE_PME_LSB + GPIN_W > ROUTE_PSW_LSB) begin : g_bad_route
    $error("wake and switch route fields overlap");
  end
  if (ROUTE_PSW_LSB + GPIN_W > REG_W) begin : g_bad_route_top
    $error("switch route field exceeds register");
  end
  if (HIGH_WDOG_BIT >= HIGH_GROUP_W) begin : g_bad_wdog
    $error("watchdog bit outside high group");
  end
  if (IRQ_BIT_PME == IRQ_BIT_PSW) begin : g_bad_irq
    $error("interrupt source bits collide");
  end
  if (IRQ_BIT_PME >= IRQ_W || IRQ_BIT_PSW >= IRQ_W) begin : g_bad_irq_w
    $error("interrupt source bit outside status width");
  end

  // ==========================================================
  // Synchronise and detect event edges
  logic [LOW_GROUP_W-1:0]  low_raw;
  logic [HIGH_GROUP_W-1:0] high_raw;
  logic [GPIN_W-1:0]       gpin_raw;
  logic [LOW_GROUP_W-1:0]  low_evt;
  logic [HIGH_GROUP_W-1:0] high_evt;
  logic [GPIN_W-1:0]       gpin_evt;

  assign low_raw  = {serial_port_c_irq, mouse_irq, keyboard_controller_irq,
                     printer_port_irq, floppy_controller_irq,
                     serial_port_a_irq, serial_port_b_irq};
  // Watchdog pin idles high; its synchroniser detects the fall
  assign high_raw = {serial_port_f_irq, serial_port_e_irq, hardware_monitor_irq,
                     watchdog_timeout_n, serial_port_d_irq, ring_indicate_b};
  assign gpin_raw = {gen_input_27, gen_input_26, gen_input_25};

  genvar gi;
  generate
    for (gi = 0; gi < LOW_GROUP_W; gi++) begin : g_low
      sync_edge u_sync (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .async_in   (low_raw[gi]),
        .rise_pulse (low_evt[gi])
      );
    end
    for (gi = 0; gi < HIGH_GROUP_W; gi++) begin : g_high
      sync_edge #(.IDLE_HIGH(gi == HIGH_WDOG_BIT)) u_sync (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .async_in   (high_raw[gi]),
        .rise_pulse (high_evt[gi])
      );
    end
    for (gi = 0; gi < GPIN_W; gi++) begin : g_gpin
      sync_edge u_sync (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .async_in   (gpin_raw[gi]),
        .rise_pulse (gpin_evt[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Control registers
  logic [7:0] enable_low_reg,  enable_low_next;
  logic [7:0] enable_high_reg, enable_high_next;
  logic [7:0] route_reg,       route_next;
  logic [7:0] irq_mask_reg,    irq_mask_next;

  always_comb begin
    enable_low_next  = enable_low_reg;
    enable_high_next = enable_high_reg;
    route_next       = route_reg;
    irq_mask_next    = irq_mask_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_ENABLE_LOW:  enable_low_next  = reg_wdata & MASK_LOW_GROUP;
        ADDR_ENABLE_HIGH: enable_high_next = reg_wdata & MASK_HIGH_GROUP;
        ADDR_ROUTE_SEL:   route_next       = reg_wdata & MASK_ROUTE;
        ADDR_IRQ_MASK:    irq_mask_next    = reg_wdata & MASK_IRQ;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      enable_low_reg  <= RESET_ZERO;
      enable_high_reg <= RESET_ZERO;
      route_reg       <= RESET_ZERO;
      irq_mask_reg    <= RESET_ZERO;
    end else begin
      enable_low_reg  <= enable_low_next;
      enable_high_reg <= enable_high_next;
      route_reg       <= route_next;
      irq_mask_reg    <= irq_mask_next;
    end
  end

  // ==========================================================
  // Status clear strobe decode
  logic clr_status_low;
  logic clr_status_high;
  logic clr_status_gpin;
  logic clr_status_irq;

  always_comb begin
    clr_status_low  = reg_wr && (reg_addr == ADDR_STATUS_LOW);
    clr_status_high = reg_wr && (reg_addr == ADDR_STATUS_HIGH);
    clr_status_gpin = reg_wr && (reg_addr == ADDR_GPIN_STATUS);
    clr_status_irq  = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
  end

  // ==========================================================
  // Sticky status flags
  logic [LOW_GROUP_W-1:0]  status_low;
  logic [HIGH_GROUP_W-1:0] status_high;
  logic [GPIN_W-1:0]       status_gpin;
  logic [IRQ_W-1:0]        status_irq;
  logic [IRQ_W-1:0]        irq_evt;
  logic                    wake_level;
  logic                    psw_level;
  logic                    wake_last_reg, wake_last_next;
  logic                    psw_last_reg,  psw_last_next;

  sticky_group #(.WIDTH(LOW_GROUP_W)) u_status_low (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .set_pulse  (low_evt),
    .clear_wr   (clr_status_low),
    .clear_bits (reg_wdata[LOW_GROUP_W-1:0]),
    .flags      (status_low)
  );

  sticky_group #(.WIDTH(HIGH_GROUP_W)) u_status_high (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .set_pulse  (high_evt),
    .clear_wr   (clr_status_high),
    .clear_bits (reg_wdata[HIGH_GROUP_W-1:0]),
    .flags      (status_high)
  );

  sticky_group #(.WIDTH(GPIN_W)) u_status_gpin (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .set_pulse  (gpin_evt),
    .clear_wr   (clr_status_gpin),
    .clear_bits (reg_wdata[GPIN_W-1:0]),
    .flags      (status_gpin)
  );

  // ==========================================================
  // Output decision
  logic [LOW_GROUP_W-1:0]  low_hit;
  logic [HIGH_GROUP_W-1:0] high_hit;
  logic [GPIN_W-1:0]       gpin_pme_hit;
  logic [GPIN_W-1:0]       gpin_psw_hit;

  always_comb begin
    low_hit      = status_low  & enable_low_reg[LOW_GROUP_W-1:0];
    high_hit     = status_high & enable_high_reg[HIGH_GROUP_W-1:0];
    gpin_pme_hit = status_gpin & route_reg[ROUTE_PME_LSB +: GPIN_W];
    gpin_psw_hit = status_gpin & route_reg[ROUTE_PSW_LSB +: GPIN_W];
    wake_level   = (|low_hit) | (|high_hit) | (|gpin_pme_hit);
    psw_level    = |gpin_psw_hit;
  end

  always_comb begin
    wake_last_next       = wake_level;
    psw_last_next        = psw_level;
    irq_evt              = '0;
    irq_evt[IRQ_BIT_PME] = wake_level & ~wake_last_reg;
    irq_evt[IRQ_BIT_PSW] = psw_level & ~psw_last_reg;
  end

  sticky_group #(.WIDTH(IRQ_W)) u_status_irq (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .set_pulse  (irq_evt),
    .clear_wr   (clr_status_irq),
    .clear_bits (reg_wdata[IRQ_W-1:0]),
    .flags      (status_irq)
  );

  // ==========================================================
  // Output and read-back registers
  logic       pme_n_reg, pme_n_next;
  logic       psw_n_reg, psw_n_next;
  logic       irq_reg,   irq_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] status_low_word;
  logic [7:0] status_high_word;
  logic [7:0] status_gpin_word;
  logic [7:0] status_irq_word;

  always_comb begin
    status_low_word                    = RESET_ZERO;
    status_high_word                   = RESET_ZERO;
    status_gpin_word                   = RESET_ZERO;
    status_irq_word                    = RESET_ZERO;
    status_low_word[LOW_GROUP_W-1:0]   = status_low;
    status_high_word[HIGH_GROUP_W-1:0] = status_high;
    status_gpin_word[GPIN_W-1:0]       = status_gpin;
    status_irq_word[IRQ_W-1:0]         = status_irq;
  end

  always_comb begin
    pme_n_next = ~wake_level;
    psw_n_next = ~psw_level;
    irq_next   = |(status_irq & irq_mask_reg[IRQ_W-1:0]);
    rdata_next = RESET_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS_LOW:  rdata_next = status_low_word;
        ADDR_STATUS_HIGH: rdata_next = status_high_word;
        ADDR_ENABLE_LOW:  rdata_next = enable_low_reg;
        ADDR_ENABLE_HIGH: rdata_next = enable_high_reg;
        ADDR_ROUTE_SEL:   rdata_next = route_reg;
        ADDR_GPIN_STATUS: rdata_next = status_gpin_word;
        ADDR_IRQ_MASK:    rdata_next = irq_mask_reg;
        ADDR_IRQ_STATUS:  rdata_next = status_irq_word;
        default:          rdata_next = RESET_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pme_n_reg     <= 1'b1;
      psw_n_reg     <= 1'b1;
      irq_reg       <= 1'b0;
      rdata_reg     <= RESET_ZERO;
      wake_last_reg <= 1'b0;
      psw_last_reg  <= 1'b0;
    end else begin
      pme_n_reg     <= pme_n_next;
      psw_n_reg     <= psw_n_next;
      irq_reg       <= irq_next;
      rdata_reg     <= rdata_next;
      wake_last_reg <= wake_last_next;
      psw_last_reg  <= psw_last_next;
    end
  end

  assign pme_n                 = pme_n_reg;
  assign power_switch_output_n = psw_n_reg;
  assign irq                   = irq_reg;
  assign reg_rdata             = rdata_reg;
endmodule // pme_wake_event_router

// ===== test/pme_wake_assertions.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module pme_wake_checker
  import pme_wake_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pme_n,
  input wire logic       power_switch_output_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_low_reserved: assert property (
    reg_rd && reg_addr == ADDR_ENABLE_LOW |=> !reg_rdata[7]) else $error("low bit 7 set");
  a_high_reserved: assert property (
    reg_rd && reg_addr == ADDR_ENABLE_HIGH |=> reg_rdata[7:6] == 2'h0) else $error("high 7:6 set");
  a_route_reserved: assert property (
    reg_rd && reg_addr == ADDR_ROUTE_SEL |=> !reg_rdata[7] && !reg_rdata[3])
    else $error("route reserved set");
  a_low_write: assert property (
    reg_wr && reg_addr == ADDR_ENABLE_LOW ##1 reg_rd && reg_addr == ADDR_ENABLE_LOW
    |=> reg_rdata == ($past(reg_wdata, 2) & MASK_LOW_GROUP)) else $error("low readback");
  a_high_write: assert property (
    reg_wr && reg_addr == ADDR_ENABLE_HIGH ##1 reg_rd && reg_addr == ADDR_ENABLE_HIGH
    |=> reg_rdata == ($past(reg_wdata, 2) & MASK_HIGH_GROUP)) else $error("high readback");
  a_route_write: assert property (
    reg_wr && reg_addr == ADDR_ROUTE_SEL ##1 reg_rd && reg_addr == ADDR_ROUTE_SEL
    |=> reg_rdata == ($past(reg_wdata, 2) & MASK_ROUTE)) else $error("route readback");
  a_reset_idle: assert property (
    $rose(arst_n) |-> pme_n && power_switch_output_n) else $error("outputs active at reset");
  a_wake_disabled: assert property (
    reg_wr && reg_addr == ADDR_ENABLE_LOW && reg_wdata == 8'h00
    ##1 reg_wr && reg_addr == ADDR_ENABLE_HIGH && reg_wdata == 8'h00
    ##1 reg_wr && reg_addr == ADDR_ROUTE_SEL && reg_wdata == 8'h00 ##1 !reg_wr [*2]
    |=> pme_n) else $error("wake held with all disabled");
endmodule // pme_wake_checker

// ===== test/pme_host.sv
`timescale 1ns/10ps
// ==========================================================
// Chipset wake logic: counts wake and switch requests
module pme_host (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Requests from device
  input  wire logic       pme_n,
  input  wire logic       power_switch_output_n,
  // Counts seen
  output logic      [7:0] wake_cnt,
  output logic      [7:0] psw_cnt
);
  logic pme_q;
  logic psw_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pme_q    <= 1'b1;
      psw_q    <= 1'b1;
      wake_cnt <= 8'h00;
      psw_cnt  <= 8'h00;
    end else begin
      pme_q <= pme_n;
      psw_q <= power_switch_output_n;
      if (pme_q && !pme_n) wake_cnt <= wake_cnt + 8'h01;
      if (psw_q && !power_switch_output_n) psw_cnt <= psw_cnt + 8'h01;
    end
  end
endmodule // pme_host

// ===== test/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import pme_wake_pkg::*;
;
  logic clk_sys, arst_n, reg_wr, reg_rd, pme_n, power_switch_output_n, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, wake_cnt, psw_cnt, d;
  logic [15:0] ev;
  int err_total, comparisons;
  always #4 clk_sys = ~clk_sys;
  pme_wake_event_router dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .serial_port_b_irq(ev[0]), .serial_port_a_irq(ev[1]),
    .floppy_controller_irq(ev[2]), .printer_port_irq(ev[3]), .keyboard_controller_irq(ev[4]),
    .mouse_irq(ev[5]), .serial_port_c_irq(ev[6]), .ring_indicate_b(ev[7]),
    .serial_port_d_irq(ev[8]), .watchdog_timeout_n(~ev[9]), .hardware_monitor_irq(ev[10]),
    .serial_port_e_irq(ev[11]), .serial_port_f_irq(ev[12]), .gen_input_25(ev[13]),
    .gen_input_26(ev[14]), .gen_input_27(ev[15]), .pme_n, .power_switch_output_n, .irq);
  pme_host u_host (.clk_sys, .arst_n, .pme_n, .power_switch_output_n, .wake_cnt, .psw_cnt);
  // ==========================================================
  // Bus and check helpers
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic hit(input int i);
    ev[i] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    ev[i] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] ad [3] = '{ADDR_ENABLE_LOW, ADDR_ENABLE_HIGH, ADDR_ROUTE_SEL};
    logic [7:0] mk [3] = '{MASK_LOW_GROUP, MASK_HIGH_GROUP, MASK_ROUTE};
    chk("pme_n", {7'h0, pme_n}, 8'h01);
    for (int j = 0; j < 3; j++) begin
      rd(ad[j]);
      chk("reset", d, 8'h00);
      wr(ad[j], 8'hff);
      rd(ad[j]);
      chk("mask", d, mk[j]);
      settle();
      chk("rdata_idle", reg_rdata, 8'h00);
      wr(ad[j], 8'h00);
    end
    @(posedge clk_sys);
    wr(8'h00, 8'hff);
    rd(8'h00);
    chk("unmapped", d, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_sources();
    logic [7:0] a, sa, b;
    for (int i = 0; i < 13; i++) begin
      a = (i < 7) ? ADDR_ENABLE_LOW : ADDR_ENABLE_HIGH;
      sa = (i < 7) ? ADDR_STATUS_LOW : ADDR_STATUS_HIGH;
      b = 8'h01 << ((i < 7) ? i : i - 7);
      hit(i);
      chk("blocked", {7'h0, pme_n}, 8'h01);
      rd(sa);
      chk("status", d, b);
      wr(a, b);
      settle();
      chk("wake", {7'h0, pme_n}, 8'h00);
      wr(sa, 8'h00);
      rd(sa);
      chk("kept", d, b);
      wr(sa, b);
      settle();
      chk("release", {7'h0, pme_n}, 8'h01);
      wr(a, 8'h00);
    end
    @(posedge clk_sys);
    $display("t_sources done");
  endtask
  task automatic t_gpin();
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_ROUTE_SEL, 8'h10 << k);
      hit(13 + k);
      chk("psw", {6'h0, power_switch_output_n, pme_n}, 8'h01);
      wr(ADDR_ROUTE_SEL, 8'h01 << k);
      settle();
      chk("pme", {6'h0, power_switch_output_n, pme_n}, 8'h02);
      wr(ADDR_GPIN_STATUS, 8'h01 << k);
      settle();
      chk("idle", {6'h0, power_switch_output_n, pme_n}, 8'h03);
    end
    $display("t_gpin done");
  endtask
  task automatic t_irq();
    rd(ADDR_IRQ_STATUS);
    chk("irq_hist", d, 8'h03);
    wr(ADDR_IRQ_STATUS, 8'h03);
    rd(ADDR_IRQ_STATUS);
    chk("irq_clr", d, 8'h00);
    wr(ADDR_ROUTE_SEL, 8'h01);
    rd(ADDR_IRQ_MASK);
    chk("mask_rst", d, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h03);
    hit(13);
    chk("irq", {7'h0, irq}, 8'h01);
    rd(ADDR_IRQ_STATUS);
    chk("irq_status", d, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    settle();
    settle();
    chk("masked", {7'h0, irq}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h01);
    settle();
    settle();
    chk("unmasked", {7'h0, irq}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    settle();
    settle();
    chk("cleared", {7'h0, irq}, 8'h00);
    reg_wr <= 1'b1;
    reg_wdata <= 8'h00;
    reg_addr <= ADDR_ENABLE_LOW;
    @(posedge clk_sys);
    reg_addr <= ADDR_ENABLE_HIGH;
    @(posedge clk_sys);
    reg_addr <= ADDR_ROUTE_SEL;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    settle();
    settle();
    chk("off", {7'h0, pme_n}, 8'h01);
    chk("wakes", wake_cnt, 8'd17);
    chk("switch", psw_cnt, 8'd3);
    $display("t_irq done");
  endtask
  initial begin
    {clk_sys, arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ev} = '0;
    err_total = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_sources();
    t_gpin();
    t_irq();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
endmodule // tb_top
bind pme_wake_event_router pme_wake_checker u_chk (.clk_sys, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .pme_n, .power_switch_output_n);
